// File: shared/spl_pkg.sv
package spl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Serial command decoding
   localparam logic [7:0] SPL_OP_RD_PROT  = 8'h3c;
   localparam logic [4:0] SPL_OP_LAST     = 5'h07;
   localparam logic [4:0] SPL_ADDR_LAST   = 5'h17;
   localparam int         SPL_ADDR_W      = 24;

   ////////////////////////////////////////////////////////////////////////
   // Sector layout: eight sectors of 64 Kbyte
   localparam int         SPL_SECTORS     = 8;
   localparam int         SPL_SEC_W       = 3;
   localparam int         SPL_SEC_LSB     = 16;

   ////////////////////////////////////////////////////////////////////////
   // Status write fields
   localparam int         SPL_LOCK_POS    = 7;
   localparam int         SPL_GLB_HI      = 5;
   localparam int         SPL_GLB_LO      = 2;
   localparam logic [3:0] SPL_GLB_UNPROT  = 4'h0;
   localparam logic [3:0] SPL_GLB_PROT    = 4'hf;

   ////////////////////////////////////////////////////////////////////////
   // Protection summary codes
   localparam logic [1:0] SPL_SUM_NONE    = 2'h0;
   localparam logic [1:0] SPL_SUM_SOME    = 2'h1;
   localparam logic [1:0] SPL_SUM_ALL     = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset, and synchroniser width
   localparam logic [7:0] SPL_FLAGS_RST   = 8'hff;
   localparam logic       SPL_LOCK_RST    = 1'h0;
   localparam logic [4:0] SPL_CNT_RST     = 5'h00;
   localparam int         SPL_SYNC_W      = 4;

   typedef enum logic [3:0] {
      SPL_ST_CMD  = 4'b0001,
      SPL_ST_ADDR = 4'b0010,
      SPL_ST_OUT  = 4'b0100,
      SPL_ST_SKIP = 4'b1000
   } spl_state_e;

endpackage

// File: core/spl_sync.sv
module spl_sync
   import spl_pkg::*;
#(
   parameter int W = SPL_SYNC_W
)
(
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Raw and synchronised levels
   input  wire logic [W-1:0] d,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] nxt_s1;
   logic [W-1:0] nxt_s2;

   // First stage feeds only the second stage
   always_comb
   begin
      nxt_s1 = s1_ff;
      nxt_s2 = s2_ff;
      if (ce)
      begin
         nxt_s1 = d;
         nxt_s2 = s1_ff;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               s1_ff[i] <= rst_val[i];
               s2_ff[i] <= rst_val[i];
            end
            else
            begin
               s1_ff[i] <= nxt_s1[i];
               s2_ff[i] <= nxt_s2[i];
            end
         end
      end
   endgenerate

   assign q = s2_ff;

endmodule // spl_sync

// File: core/spl_top.sv
module spl_top
   import spl_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // Serial pins
   input  wire logic                 sck,
   input  wire logic                 cs_n,
   input  wire logic                 si,
   input  wire logic                 wp_n,
   output logic                      so,
   output logic                      so_oe,
   // Sector and status write requests
   input  wire logic                 sec_prot_req,
   input  wire logic                 sec_unprot_req,
   input  wire logic [SPL_SEC_W-1:0] sec_idx,
   input  wire logic                 sr_wr_req,
   input  wire logic [7:0]           sr_wr_data,
   // Status
   output logic                      protection_regs_lock_bit,
   output logic [1:0]                software_protect_summary,
   output logic                      hw_locked,
   output logic [SPL_SECTORS-1:0]    sector_flags,
   output logic                      req_ignored
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [SPL_SYNC_W-1:0] pins_s;
   logic                  sck_s;
   logic                  cs_n_s;
   logic                  si_s;
   logic                  wp_n_s;

   spl_sync #(.W(SPL_SYNC_W)) u_sync (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .d       ({sck, cs_n, si, wp_n}),
      .rst_val (4'h7),
      .q       (pins_s)
   );

   assign {sck_s, cs_n_s, si_s, wp_n_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////
   // Serial read of the sector protection flag
   spl_state_e            state_ff;
   spl_state_e            nxt_state;
   logic                  sck_prev_ff;
   logic                  nxt_sck_prev;
   logic [4:0]            cnt_ff;
   logic [4:0]            nxt_cnt;
   logic [SPL_ADDR_W-1:0] sh_ff;
   logic [SPL_ADDR_W-1:0] nxt_sh;
   logic [SPL_SEC_W-1:0]  sec_ff;
   logic [SPL_SEC_W-1:0]  nxt_sec;
   logic                  so_ff;
   logic                  nxt_so;
   logic                  so_oe_ff;
   logic                  nxt_so_oe;
   logic                  sck_rise;
   logic                  sck_fall;
   logic                  cur_flag;
   logic [SPL_SECTORS-1:0] flags_ff;

   assign sck_rise = sck_s & ~sck_prev_ff;
   assign sck_fall = ~sck_s & sck_prev_ff;
   assign cur_flag = flags_ff[sec_ff];

   always_comb
   begin
      logic [SPL_ADDR_W-1:0] shifted;
      shifted      = {sh_ff[SPL_ADDR_W-2:0], si_s};
      nxt_state    = state_ff;
      nxt_sck_prev = sck_prev_ff;
      nxt_cnt      = cnt_ff;
      nxt_sh       = sh_ff;
      nxt_sec      = sec_ff;
      nxt_so       = so_ff;
      nxt_so_oe    = so_oe_ff;
      if (ce)
      begin
         nxt_sck_prev = sck_s;
         if (cs_n_s)
         begin
            // Deselect aborts at any bit and floats the output
            nxt_state = SPL_ST_CMD;
            nxt_cnt   = SPL_CNT_RST;
            nxt_so_oe = 1'b0;
         end
         else
         begin
            unique case (state_ff)
               SPL_ST_CMD:
               begin
                  if (sck_rise)
                  begin
                     nxt_sh  = shifted;
                     nxt_cnt = cnt_ff + 5'h01;
                     if (cnt_ff == SPL_OP_LAST)
                     begin
                        nxt_cnt = SPL_CNT_RST;
                        if (shifted[7:0] == SPL_OP_RD_PROT)
                           nxt_state = SPL_ST_ADDR;
                        else
                           nxt_state = SPL_ST_SKIP;
                     end
                  end
               end
               SPL_ST_ADDR:
               begin
                  if (sck_rise)
                  begin
                     nxt_sh  = shifted;
                     nxt_cnt = cnt_ff + 5'h01;
                     if (cnt_ff == SPL_ADDR_LAST)
                     begin
                        // Any address inside the sector selects it
                        nxt_sec   = shifted[SPL_SEC_LSB +: SPL_SEC_W];
                        nxt_state = SPL_ST_OUT;
                     end
                  end
               end
               SPL_ST_OUT:
               begin
                  // Every bit of the byte equals the flag, so the byte
                  // repeats without a bit counter
                  if (sck_fall)
                  begin
                     nxt_so    = cur_flag;
                     nxt_so_oe = 1'b1;
                  end
               end
               SPL_ST_SKIP:
               begin
                  nxt_so_oe = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff    <= SPL_ST_CMD;
         sck_prev_ff <= 1'b0;
         cnt_ff      <= SPL_CNT_RST;
         sh_ff       <= '0;
         sec_ff      <= '0;
         so_ff       <= 1'b0;
         so_oe_ff    <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         sck_prev_ff <= nxt_sck_prev;
         cnt_ff      <= nxt_cnt;
         sh_ff       <= nxt_sh;
         sec_ff      <= nxt_sec;
         so_ff       <= nxt_so;
         so_oe_ff    <= nxt_so_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protection flags and lock bit
   logic                   lock_ff;
   logic                   nxt_lock;
   logic [SPL_SECTORS-1:0] nxt_flags;
   logic [1:0]             sum_ff;
   logic [1:0]             nxt_sum;
   logic                   hw_ff;
   logic                   nxt_hw;
   logic                   ign_ff;
   logic                   nxt_ign;
   logic                   hw_active;
   logic [3:0]             glb;

   // The pin never touches the flags; it only gates the lock
   assign hw_active = ~wp_n_s & lock_ff;
   assign glb       = sr_wr_data[SPL_GLB_HI:SPL_GLB_LO];

   always_comb
   begin
      nxt_lock  = lock_ff;
      nxt_flags = flags_ff;
      nxt_ign   = ign_ff;
      if (ce)
      begin
         nxt_ign = 1'b0;
         // Sector commands only while unlocked
         if (sec_prot_req | sec_unprot_req)
         begin
            if (lock_ff)
               nxt_ign = 1'b1;
            else
               nxt_flags[sec_idx] = sec_prot_req;
         end
         if (sr_wr_req)
         begin
            if (hw_active)
               nxt_ign = 1'b1;
            else
            begin
               // Only the lock bit is stored
               nxt_lock = sr_wr_data[SPL_LOCK_POS];
               // Flags stay soft-locked through an unlocking write
               if (!lock_ff)
               begin
                  if (glb == SPL_GLB_UNPROT)
                     nxt_flags = '0;
                  else if (glb == SPL_GLB_PROT)
                     nxt_flags = '1;
               end
            end
         end
      end
      nxt_hw = nxt_lock & ~wp_n_s;
      if (&nxt_flags)
         nxt_sum = SPL_SUM_ALL;
      else if (|nxt_flags)
         nxt_sum = SPL_SUM_SOME;
      else
         nxt_sum = SPL_SUM_NONE;
      if (!ce)
      begin
         nxt_hw  = hw_ff;
         nxt_sum = sum_ff;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lock_ff  <= SPL_LOCK_RST;
         flags_ff <= SPL_FLAGS_RST;
         sum_ff   <= SPL_SUM_ALL;
         hw_ff    <= 1'b0;
         ign_ff   <= 1'b0;
      end
      else
      begin
         lock_ff  <= nxt_lock;
         flags_ff <= nxt_flags;
         sum_ff   <= nxt_sum;
         hw_ff    <= nxt_hw;
         ign_ff   <= nxt_ign;
      end
   end

   assign so                       = so_ff;
   assign so_oe                    = so_oe_ff;
   assign protection_regs_lock_bit = lock_ff;
   assign software_protect_summary = sum_ff;
   assign hw_locked                = hw_ff;
   assign sector_flags             = flags_ff;
   assign req_ignored              = ign_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_addr_done;
      ce && !cs_n_s && state_ff == SPL_ST_ADDR && sck_rise
         && cnt_ff == SPL_ADDR_LAST;
   endsequence
   sequence s_out_edge;
      ce && !cs_n_s && state_ff == SPL_ST_OUT && sck_fall;
   endsequence

   a_addr_to_out: assert property (
      s_addr_done |=> state_ff == SPL_ST_OUT)
      else $error("address end did not start output");
   a_prot_data: assert property (
      s_out_edge |=> so_oe_ff && so_ff == $past(cur_flag))
      else $error("output bit differs from sector flag");
   a_cs_float: assert property (
      ce && cs_n_s |=> !so_oe_ff && state_ff == SPL_ST_CMD)
      else $error("output still driven after deselect");
   a_summary_code: assert property (
      (&flags_ff) ? sum_ff == SPL_SUM_ALL :
      ((|flags_ff) ? sum_ff == SPL_SUM_SOME : sum_ff == SPL_SUM_NONE))
      else $error("summary does not match flags");
   a_hw_lock_flag: assert property (
      ce |=> hw_ff == (lock_ff && !$past(wp_n_s)))
      else $error("hardware lock flag wrong");
   a_hw_freeze: assert property (
      ce && hw_active && sr_wr_req |=> $stable(lock_ff)
         && $stable(flags_ff) && req_ignored)
      else $error("write accepted under hardware lock");
   // A reset is the one legal way out, so a cycle in reset is exempt
   a_lock_sticky: assert property (
      ce && lock_ff && !wp_n_s && !rst |=> lock_ff)
      else $error("lock cleared while pin low");
   a_unlock_no_glb: assert property (
      ce && sr_wr_req && lock_ff && wp_n_s |=> $stable(flags_ff)
         && lock_ff == $past(sr_wr_data[SPL_LOCK_POS]))
      else $error("unlocking write changed flags");
   a_glb_unprot: assert property (
      ce && sr_wr_req && !lock_ff && glb == SPL_GLB_UNPROT
         |=> flags_ff == '0)
      else $error("global unprotect missed");
   a_glb_prot: assert property (
      ce && sr_wr_req && !lock_ff && glb == SPL_GLB_PROT
         |=> flags_ff == '1)
      else $error("global protect missed");
   a_sec_refused: assert property (
      ce && lock_ff && !sr_wr_req && (sec_prot_req || sec_unprot_req)
         |=> $stable(flags_ff) && req_ignored)
      else $error("sector command accepted while locked");

endmodule // spl_top

// File: sim/spl_host_model.sv
////////////////////////////////////////////////////////////////////////
// Serial host: mode 0 or 3, clock stands still between frames
module spl_host_model
(
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // Half period well above the 3 clk minimum, so the output settles
   localparam int HALF = 6;

   // Released output shows the inverse of its last bit, so a late
   // sample cannot pass by luck
   wire logic so_line = so_oe ? so : ~so;

   initial
   begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic shift_bits(input logic [31:0] bits, input int n,
                             output logic [31:0] got);
      got = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         // Falling edge launches the next bit on both sides
         sck <= 1'b0;
         si  <= bits[i];
         wait_clk(HALF);
         got = {got[30:0], so_line};
         sck <= 1'b1;
         wait_clk(HALF);
      end
   endtask

   task automatic frame(input logic mode3, input logic [7:0] op,
                        input logic [23:0] addr, input int nout,
                        output logic [31:0] got, output logic oe_seen);
      logic [31:0] dummy;
      // Idle level is set while deselected, so no edge lands in the frame
      sck  <= mode3;
      wait_clk(HALF);
      cs_n <= 1'b0;
      wait_clk(HALF);
      shift_bits({op, addr}, 32, dummy);
      shift_bits(32'h0, nout, got);
      sck  <= mode3;
      wait_clk(HALF);
      oe_seen = so_oe;
      cs_n <= 1'b1;
      // Released data line must not keep showing the last bit
      si   <= ~si;
      wait_clk(HALF);
   endtask

endmodule // spl_host_model

// File: sim/testbench.sv
module testbench
   import spl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                 clk;
   logic                 rst;
   logic                 ce;
   logic                 wp_n;
   logic                 sck;
   logic                 cs_n;
   logic                 si;
   logic                 so;
   logic                 so_oe;
   logic                 sec_prot_req;
   logic                 sec_unprot_req;
   logic [SPL_SEC_W-1:0] sec_idx;
   logic                 sr_wr_req;
   logic [7:0]           sr_wr_data;
   logic                 protection_regs_lock_bit;
   logic [1:0]           software_protect_summary;
   logic                 hw_locked;
   logic [7:0]           sector_flags;
   logic                 req_ignored;
   int                   mismatches;
   int                   samples_checked;
   int                   ign_cnt;
   int                   cycles;
   logic [31:0]          got;
   logic                 oe;

   spl_top dut (
      .clk(clk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
      .wp_n(wp_n), .so(so), .so_oe(so_oe), .sec_prot_req(sec_prot_req),
      .sec_unprot_req(sec_unprot_req), .sec_idx(sec_idx),
      .sr_wr_req(sr_wr_req), .sr_wr_data(sr_wr_data),
      .protection_regs_lock_bit(protection_regs_lock_bit),
      .software_protect_summary(software_protect_summary),
      .hw_locked(hw_locked), .sector_flags(sector_flags),
      .req_ignored(req_ignored)
   );

   spl_host_model host (
      .clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Refusal pulses are counted, so their exact cycle does not matter
   always @(posedge clk)
   begin
      if (req_ignored === 1'b1)
         ign_cnt++;
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("mismatches=%0d samples_checked=%0d", mismatches,
               samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // kind 0 protect, 1 unprotect, 2 status write
   task automatic req(input int kind, input logic [7:0] v);
      @(posedge clk);
      sec_prot_req   <= (kind == 0);
      sec_unprot_req <= (kind == 1);
      sr_wr_req      <= (kind == 2);
      sec_idx        <= v[2:0];
      sr_wr_data     <= v;
      @(posedge clk);
      sec_prot_req   <= 1'b0;
      sec_unprot_req <= 1'b0;
      sr_wr_req      <= 1'b0;
      cyc(2);
   endtask

   task automatic st(input logic [7:0] f, input logic l,
                     input logic [1:0] s);
      chk(sector_flags, f);
      chk(protection_regs_lock_bit, l);
      chk(software_protect_summary, s);
   endtask

   task automatic rd(input logic m, input logic [23:0] a,
                     input logic [15:0] e);
      host.frame(m, SPL_OP_RD_PROT, a, 16, got, oe);
      chk(got[15:0], e);
      chk(oe, 1'b1);
   endtask

   // Write-protect passes a synchroniser; give it time to land
   task automatic set_wp(input logic v);
      wp_n <= v;
      cyc(4);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, ce, wp_n} = 3'b111;
      {sec_prot_req, sec_unprot_req, sr_wr_req} = 3'b000;
      sec_idx = '0;
      sr_wr_data = 8'h00;
      mismatches = 0;
      samples_checked = 0;
      ign_cnt = 0;
      cycles = 0;
      cyc(5);
      rst <= 1'b0;
      cyc(2);
      st(8'hff, 1'b0, SPL_SUM_ALL);
      chk({hw_locked, so_oe}, 2'b00);
      req(2, 8'h00);
      st(8'h00, 1'b0, SPL_SUM_NONE);
      req(0, 8'h05);
      st(8'h20, 1'b0, SPL_SUM_SOME);
      rd(1'b0, 24'h051234, 16'hffff);
      set_wp(1'b0);
      rd(1'b1, 24'h04ffff, 16'h0000);
      rd(1'b1, 24'h050000, 16'hffff);
      chk(hw_locked, 1'b0);
      set_wp(1'b1);
      host.frame(1'b0, SPL_OP_RD_PROT, 24'h050000, 3, got, oe);
      chk({oe, so_oe}, 2'b10);
      host.frame(1'b1, 8'h03, 24'h050000, 8, got, oe);
      chk(oe, 1'b0);
      req(2, 8'h7f);
      st(8'hff, 1'b0, SPL_SUM_ALL);
      req(2, 8'h00);
      req(2, 8'hbc);
      st(8'hff, 1'b1, SPL_SUM_ALL);
      req(1, 8'h03);
      st(8'hff, 1'b1, SPL_SUM_ALL);
      chk(ign_cnt, 1);
      set_wp(1'b0);
      chk(hw_locked, 1'b1);
      req(2, 8'h00);
      req(1, 8'h02);
      st(8'hff, 1'b1, SPL_SUM_ALL);
      chk(ign_cnt, 3);
      set_wp(1'b1);
      chk(hw_locked, 1'b0);
      req(2, 8'h00);
      st(8'hff, 1'b0, SPL_SUM_ALL);
      // A write offered while the enable is low must not be taken
      ce <= 1'b0;
      req(2, 8'h00);
      ce <= 1'b1;
      st(8'hff, 1'b0, SPL_SUM_ALL);
      req(2, 8'h00);
      st(8'h00, 1'b0, SPL_SUM_NONE);
      set_wp(1'b0);
      req(2, 8'h80);
      st(8'h00, 1'b1, SPL_SUM_NONE);
      chk(hw_locked, 1'b1);
      rst <= 1'b1;
      cyc(1);
      rst <= 1'b0;
      cyc(2);
      st(8'hff, 1'b0, SPL_SUM_ALL);
      tally_and_finish();
   end

endmodule // testbench
